/* design/led_cfg_device.sv */
// Purpose: command interpreter of a 12 output led driver
// Assumes: frames arrive msb first, sampled at link clock rise
// Notes: diagnosis inputs come from logic on core_clk
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "led_link_defines.svh"
module led_cfg_device (
  input wire logic core_clk,
  input wire logic resetn,
  led_link_if.device link,
  input wire logic temp_warn,
  input wire logic temp_shutdown,
  input wire logic supply_fault,
  input wire logic clock_fault,
  input wire logic [1:0] ir_result,
  input wire logic [11:0] supply_short_result,
  input wire logic [11:0] ground_short_result,
  input wire logic [11:0] open_result,
  input wire logic [11:0] adjacent_short_result,
  input wire logic [11:0] output_state_result,
  output logic [5:0] ctrl1_word,
  output logic [6:0] ctrl2_word,
  output logic [95:0] current_codes,
  output logic [35:0] pwm_select,
  output logic [1:0] pwm_steps,
  output logic [3:0] frame_rate,
  output logic [59:0] duty_values,
  output logic [11:0] output_enable_mask,
  output logic [11:0] supply_short_mask,
  output logic [11:0] ground_short_mask,
  output logic [11:0] open_detect_mask,
  output logic [23:0] short_threshold,
  output logic [11:0] led_drive,
  output logic [4:0] lock_flags
);

  // ****************************************
  // state and reset image
  // ****************************************
  led_link_pkg::dev_state_type q; // registered state
  led_link_pkg::dev_state_type d; // next state
  // every lock reads zero here, so all groups start writable
  localparam led_link_pkg::dev_state_type RST_IMG = '{
    ctrl2: `RST_CTRL2,
    psel: `RST_PSEL,
    pstep: `RST_PSTEP,
    shmask: `RST_DETMASK,
    slmask: `RST_DETMASK,
    opmask: `RST_DETMASK,
    st1: `RST_ST1,          // por flag starts at one
    res_sup: `RST_RES,
    res_gnd: `RST_RES,
    res_open: `RST_RES,
    res_adj: `RST_RES,
    ir: `RST_IR,
    default: '0
  };

  // ****************************************
  // next state
  // ****************************************
  // one process: link sampling, frame decode, execution, flag capture
  always_comb begin
    logic rise;
    logic lat_rise;
    logic lat_fall;
    logic [7:0] cmd_n;
    logic [95:0] rd_raw;
    logic [6:0] rd_w;
    logic [95:0] rdv;
    rise = 1'b0;
    lat_rise = 1'b0;
    lat_fall = 1'b0;
    cmd_n = 8'h00;
    rd_raw = 96'h0;
    rd_w = 7'h00;
    rdv = 96'h0;
    d = q;
    // three stage synchronisers; a level counts once stages 2 and 3 agree
    d.sclk = {q.sclk[1:0], link.link_clk};
    d.ssin = {q.ssin[1:0], link.sin};
    d.slat = {q.slat[1:0], link.latch};
    if (q.sclk[2] == q.sclk[1]) begin
      d.clk_st = q.sclk[1];
    end
    if (q.ssin[2] == q.ssin[1]) begin
      d.sin_st = q.ssin[1];
    end
    if (q.slat[2] == q.slat[1]) begin
      d.lat_st = q.slat[1];
    end
    rise = !q.clk_st && d.clk_st;
    lat_rise = !q.lat_st && d.lat_st;
    lat_fall = q.lat_st && !d.lat_st;
    cmd_n = {q.sh[6:0], q.sin_st};

    // read selection, decided as the eighth command bit lands
    if (cmd_n[7:4] == `OP_READ) begin
      case (cmd_n[3:0])
        `RI_CTRL1: {rd_w, rd_raw} = {`W_CTRL1, 96'(q.ctrl1)};
        `RI_CTRL2: {rd_w, rd_raw} = {`W_CTRL2, 96'(q.ctrl2)};
        `RI_CUR: {rd_w, rd_raw} = {`W_CUR, q.cur};
        `RI_PSEL: {rd_w, rd_raw} = {`W_PSEL, 96'(q.psel)};
        `RI_PSTEP: {rd_w, rd_raw} = {`W_PSTEP, 96'(q.pstep)}; // one read
        `RI_DUTY: {rd_w, rd_raw} = {`W_DUTY, 96'(q.duty)};
        `RI_OMASK: {rd_w, rd_raw} = {`W_MASK, 96'(q.omask)};
        `RI_SHMASK: {rd_w, rd_raw} = {`W_MASK, 96'(q.shmask)};
        `RI_SLMASK: {rd_w, rd_raw} = {`W_MASK, 96'(q.slmask)};
        `RI_OPMASK: {rd_w, rd_raw} = {`W_MASK, 96'(q.opmask)};
        `RI_VSH: {rd_w, rd_raw} = {`W_VSH, 96'(q.vsh)};
        default: rd_w = 7'h00; // unknown index reads as zeros
      endcase
    end else if (cmd_n[7:4] == `OP_DIAG) begin
      case (cmd_n[3:0])
        `DI_ST1: {rd_w, rd_raw} = {`W_ST1, 96'(q.st1)};
        `DI_ST2: {rd_w, rd_raw} = {`W_ST2, 96'(q.locks)};
        `DI_IR: {rd_w, rd_raw} = {`W_IR, 96'(q.ir)};
        `DI_SUP_SHORT: {rd_w, rd_raw} = {`W_MASK, 96'(q.res_sup)};
        `DI_GND_SHORT: {rd_w, rd_raw} = {`W_MASK, 96'(q.res_gnd)};
        `DI_OPEN: {rd_w, rd_raw} = {`W_MASK, 96'(q.res_open)};
        `DI_ADJ: {rd_w, rd_raw} = {`W_MASK, 96'(q.res_adj)};
        `DI_STATE: {rd_w, rd_raw} = {`W_MASK, 96'(q.res_state)};
        default: rd_w = 7'h00;
      endcase
    end
    // left align so the msb leaves first
    rdv = rd_raw << (7'h60 - rd_w);

    // ****************************************
    // framing
    // ****************************************
    if (lat_rise) begin
      d.bits = 7'h00;
      d.so = 96'h0;
    end else if (q.lat_st && rise) begin
      d.sh = {q.sh[94:0], q.sin_st};
      if (q.bits != 7'h7F) begin
        d.bits = q.bits + 7'h01; // saturates on overlong frames
      end
      if (q.bits == 7'h07) begin
        d.cmd = cmd_n;
        d.so = rdv;
      end else if (q.bits > 7'h07) begin
        d.so = {q.so[94:0], 1'b0};
      end
    end

    // ****************************************
    // execution at end of frame
    // ****************************************
    // payload is the last bits before latch drops; short frames do nothing
    if (lat_fall && q.bits >= 7'h08) begin
      case (q.cmd[7:4])
        `OP_WRITE: begin
          // writes to a locked group are dropped silently
          case (q.cmd[3:0])
            `RI_CTRL1: if (!q.locks[`LK_R]) d.ctrl1 = q.sh[5:0];
            `RI_CTRL2: if (!q.locks[`LK_R]) d.ctrl2 = q.sh[6:0];
            `RI_CUR: if (!q.locks[`LK_C]) d.cur = q.sh;
            `RI_PSEL: if (!q.locks[`LK_P]) d.psel = q.sh[35:0];
            `RI_PSTEP: if (!q.locks[`LK_P]) d.pstep = q.sh[5:0];
            `RI_DUTY: if (!q.locks[`LK_W]) d.duty = q.sh[59:0];
            `RI_OMASK: if (!q.locks[`LK_M]) d.omask = q.sh[11:0];
            `RI_SHMASK: if (!q.locks[`LK_M]) d.shmask = q.sh[11:0];
            `RI_SLMASK: if (!q.locks[`LK_M]) d.slmask = q.sh[11:0];
            `RI_OPMASK: if (!q.locks[`LK_M]) d.opmask = q.sh[11:0];
            `RI_VSH: if (!q.locks[`LK_M]) d.vsh = q.sh[23:0];
            default: d.ctrl1 = q.ctrl1;
          endcase
        end
        `OP_LOCK: begin
          // one bit per group
          if (q.cmd[3:0] <= 4'(`LK_M)) begin
            d.locks[q.cmd[2:0]] = 1'b1;
          end
        end
        `OP_MISC: begin
          case (q.cmd[3:0])
            `MS_CLR_POR: d.st1[`ST_POR] = 1'b0;
            `MS_CLR_ST: begin
              d.st1[5:0] = 6'h00;
              d.ir = 2'h0;
              d.res_sup = 12'h000;
              d.res_gnd = 12'h000;
              d.res_open = 12'h000;
              d.res_adj = 12'h000;
              d.res_state = 12'h000;
            end
            `MS_CLK_CHK: d.st1[`ST_CERR] = clock_fault;
            default: d.st1 = q.st1;
          endcase
        end
        default: d.cmd = q.cmd; // reads and unknown ops change nothing
      endcase
    end

    // ****************************************
    // hardware flags, applied last so a set beats a clear
    // ****************************************
    d.st1[`ST_WARM] = d.st1[`ST_WARM] | temp_warn;
    d.st1[`ST_HOT] = d.st1[`ST_HOT] | temp_shutdown;
    d.st1[`ST_SHORT] = d.st1[`ST_SHORT] | (|(supply_short_result | ground_short_result));
    d.st1[`ST_OPEN] = d.st1[`ST_OPEN] | (|open_result);
    d.st1[`ST_ADJ] = d.st1[`ST_ADJ] | (|adjacent_short_result);
    d.st1[`ST_SUPPLY] = d.st1[`ST_SUPPLY] | supply_fault;
    d.st1[`ST_CERR] = d.st1[`ST_CERR] | clock_fault;
    d.ir = d.ir | ir_result;
    d.res_sup = d.res_sup | supply_short_result;
    d.res_gnd = d.res_gnd | ground_short_result;
    d.res_open = d.res_open | open_result;
    d.res_adj = d.res_adj | adjacent_short_result;
    d.res_state = output_state_result; // live state, not sticky
    // leds light only once the mask group is locked
    d.led = d.omask & {12{d.locks[`LK_M]}};
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= RST_IMG;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs, all straight from flops
  // ****************************************
  assign link.sout = q.so[95];
  assign ctrl1_word = q.ctrl1;
  assign ctrl2_word = q.ctrl2;
  assign current_codes = q.cur;
  assign pwm_select = q.psel;
  assign pwm_steps = q.pstep[5:4];
  assign frame_rate = q.pstep[3:0];
  assign duty_values = q.duty;
  assign output_enable_mask = q.omask;
  assign supply_short_mask = q.shmask;
  assign ground_short_mask = q.slmask;
  assign open_detect_mask = q.opmask;
  assign short_threshold = q.vsh;
  assign led_drive = q.led;
  assign lock_flags = q.locks;

endmodule

/* design/led_link_defines.svh */
// Purpose: shared numbers of the led driver command link
// Assumes: included by bare name from the device and host design files
// Notes: command byte is op in [7:4], index in [3:0]
`ifndef LED_LINK_DEFINES_SVH
`define LED_LINK_DEFINES_SVH

// ****************************************
// command opcodes
// ****************************************
`define OP_WRITE 4'h1
`define OP_READ 4'h2
`define OP_LOCK 4'h3
`define OP_MISC 4'h4
`define OP_DIAG 4'h5

// ****************************************
// configuration register indices
// ****************************************
`define RI_CTRL1 4'h0
`define RI_CTRL2 4'h1
`define RI_CUR 4'h2
`define RI_PSEL 4'h3
`define RI_PSTEP 4'h4
`define RI_DUTY 4'h5
`define RI_OMASK 4'h6
`define RI_SHMASK 4'h7
`define RI_SLMASK 4'h8
`define RI_OPMASK 4'h9
`define RI_VSH 4'hA

// ****************************************
// diagnosis read indices and misc commands
// ****************************************
`define DI_ST1 4'h0
`define DI_ST2 4'h1
`define DI_IR 4'h2
`define DI_SUP_SHORT 4'h3
`define DI_GND_SHORT 4'h4
`define DI_OPEN 4'h5
`define DI_ADJ 4'h6
`define DI_STATE 4'h7
`define MS_CLR_POR 4'h0
`define MS_CLR_ST 4'h1
`define MS_CLK_CHK 4'h2

// ****************************************
// payload widths in bits
// ****************************************
`define W_CTRL1 7'h06
`define W_CTRL2 7'h07
`define W_CUR 7'h60
`define W_PSEL 7'h24
`define W_PSTEP 7'h06
`define W_DUTY 7'h3C
`define W_MASK 7'h0C
`define W_VSH 7'h18
`define W_ST1 7'h08
`define W_ST2 7'h05
`define W_IR 7'h02

// ****************************************
// lock groups and status word 1 bits
// ****************************************
`define LK_R 3'h0
`define LK_C 3'h1
`define LK_P 3'h2
`define LK_W 3'h3
`define LK_M 3'h4
`define ST_WARM 0
`define ST_HOT 1
`define ST_SHORT 2
`define ST_OPEN 3
`define ST_ADJ 4
`define ST_SUPPLY 5
`define ST_CERR 6
`define ST_POR 7

// ****************************************
// reset values
// ****************************************
`define RST_CTRL2 7'h7F
`define RST_PSEL 36'h249249249
`define RST_PSTEP 6'h08
`define RST_DETMASK 12'hFFF
`define RST_ST1 8'hFF
`define RST_RES 12'hFFF
`define RST_IR 2'h3

// ****************************************
// host controller map and timing
// ****************************************
`define HA_CMD 5'h00
`define HA_WD0 5'h04
`define HA_WD1 5'h08
`define HA_WD2 5'h0C
`define HA_RD0 5'h10
`define HA_RD1 5'h14
`define HA_RD2 5'h18
`define HA_STAT 5'h1C
`define CLK_NS 8
`define SETTLE_MS 30
`define LINK_HALF 8

`endif

/* design/led_link_pkg.sv */
// Purpose: state types of both link ends
// Assumes: nothing
// Notes: each module keeps all its state in one struct
package led_link_pkg;

  // ****************************************
  // device end state
  // ****************************************
  typedef struct packed {
    logic [2:0] sclk;    // link clock synchroniser
    logic [2:0] ssin;    // serial in synchroniser
    logic [2:0] slat;    // latch synchroniser
    logic clk_st;        // filtered link clock
    logic sin_st;        // filtered serial in
    logic lat_st;        // filtered latch
    logic [6:0] bits;    // bits seen this frame
    logic [7:0] cmd;     // command byte of frame
    logic [95:0] sh;     // incoming bits, right aligned
    logic [95:0] so;     // outgoing bits, msb first
    logic [5:0] ctrl1;
    logic [6:0] ctrl2;
    logic [95:0] cur;
    logic [35:0] psel;
    logic [5:0] pstep;   // steps [5:4], frame rate [3:0]
    logic [59:0] duty;
    logic [11:0] omask;
    logic [11:0] shmask;
    logic [11:0] slmask;
    logic [11:0] opmask;
    logic [23:0] vsh;
    logic [4:0] locks;
    logic [7:0] st1;
    logic [11:0] res_sup;   // sticky supply short results
    logic [11:0] res_gnd;   // sticky ground short results
    logic [11:0] res_open;  // sticky open results
    logic [11:0] res_adj;   // sticky adjacent short results
    logic [11:0] res_state; // live driver state
    logic [1:0] ir;
    logic [11:0] led;    // drive enables toward outputs
  } dev_state_type;

  // ****************************************
  // host end state
  // ****************************************
  typedef enum logic [1:0] {H_IDLE, H_HOLD, H_SHIFT, H_TAIL} host_fsm_type;

  typedef struct packed {
    host_fsm_type fsm;
    logic [7:0] cnt;     // half period counter
    logic lclk;
    logic sinb;
    logic latch;
    logic [103:0] tx;    // command then payload, msb first
    logic [6:0] n;       // bits sent
    logic [6:0] total;
    logic [7:0] cmd;
    logic [95:0] wd;
    logic [95:0] rx;
    logic [2:0] sso;     // serial out synchroniser
    logic so_st;
    logic [31:0] settle; // wait after output lock
    logic [31:0] rdata;
  } host_state_type;

endpackage

/* design/led_link_if.sv */
// Purpose: four line serial link between host and driver
// Assumes: host makes link_clk, sin and latch
// Notes: latch high frames one command
`timescale 1ns/1ps
interface led_link_if;
  logic link_clk; // serial clock from host
  logic sin;      // data toward device
  logic latch;    // frame strobe
  logic sout;     // read data toward host

  modport device (input link_clk, input sin, input latch, output sout);
  modport host (output link_clk, output sin, output latch, input sout);
endinterface

/* design/led_cfg_host.sv */
// Purpose: host end, sends one command frame per software order
// Assumes: software sequences commands through the register port
// Notes: link clock is made here by a divider of core_clk
`timescale 1ns/1ps
`include "led_link_defines.svh"
module led_cfg_host #(
  parameter int unsigned HALF = `LINK_HALF, // core cycles per link half period
  parameter int unsigned SETTLE_CYC = `SETTLE_MS * 1000000 / `CLK_NS + 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  led_link_if.host link,
  input wire logic [4:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);

  // ****************************************
  // state
  // ****************************************
  led_link_pkg::host_state_type q; // registered state
  led_link_pkg::host_state_type d; // next state
  localparam led_link_pkg::host_state_type RST_IMG = '{
    fsm: led_link_pkg::H_IDLE,
    default: '0
  };

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic tick;
    logic [103:0] txn;
    tick = 1'b0;
    txn = 104'h0;
    d = q;
    d.rdata = 32'h0;
    tick = (q.cnt == 8'(HALF - 1));
    // read data return synchroniser
    d.sso = {q.sso[1:0], link.sout};
    if (q.sso[2] == q.sso[1]) begin
      d.so_st = q.sso[1];
    end
    // settle timer runs down on its own
    if (q.settle != 32'h0) begin
      d.settle = q.settle - 32'h1;
    end

    // register port; writes ignored while a frame is in flight
    if (wr && q.fsm == led_link_pkg::H_IDLE) begin
      case (addr)
        `HA_CMD: begin
          d.cmd = wdata[7:0];
          d.total = 7'h08 + wdata[14:8];
          d.fsm = led_link_pkg::H_HOLD;
        end
        `HA_WD0: d.wd[31:0] = wdata;
        `HA_WD1: d.wd[63:32] = wdata;
        `HA_WD2: d.wd[95:64] = wdata;
        default: d.cmd = q.cmd;
      endcase
    end
    if (rd) begin
      case (addr)
        `HA_RD0: d.rdata = q.rx[31:0];
        `HA_RD1: d.rdata = q.rx[63:32];
        `HA_RD2: d.rdata = q.rx[95:64];
        `HA_STAT: d.rdata = {30'h0, (q.settle != 32'h0), (q.fsm != led_link_pkg::H_IDLE)};
        default: d.rdata = 32'h0;
      endcase
    end

    // ****************************************
    // frame sequencer
    // ****************************************
    case (q.fsm)
      led_link_pkg::H_IDLE: begin
        d.cnt = 8'h00;
      end
      led_link_pkg::H_HOLD: begin
        // status and results wait out the settle time
        if (q.cmd[7:4] != `OP_DIAG || q.settle == 32'h0) begin
          txn = {q.cmd, q.wd << (7'h60 - (q.total - 7'h08))};
          d.tx = txn;
          d.sinb = txn[103];
          d.latch = 1'b1;
          d.n = 7'h00;
          d.cnt = 8'h00;
          d.rx = 96'h0;
          d.fsm = led_link_pkg::H_SHIFT;
        end
      end
      led_link_pkg::H_SHIFT: begin
        d.cnt = q.cnt + 8'h01;
        if (tick) begin
          d.cnt = 8'h00;
          if (!q.lclk) begin
            // sample read bit just before the rise that advances it
            if (q.n >= 7'h08) begin
              d.rx = {q.rx[94:0], q.so_st};
            end
            d.lclk = 1'b1;
          end else begin
            d.lclk = 1'b0;
            d.n = q.n + 7'h01;
            d.tx = {q.tx[102:0], 1'b0};
            d.sinb = q.tx[102];
            if (q.n + 7'h01 == q.total) begin
              d.fsm = led_link_pkg::H_TAIL;
            end
          end
        end
      end
      led_link_pkg::H_TAIL: begin
        d.cnt = q.cnt + 8'h01;
        if (tick) begin
          d.cnt = 8'h00;
          if (q.latch) begin
            d.latch = 1'b0;
            d.sinb = 1'b0;
            // output lock starts the wait before diagnosis
            if (q.cmd == {`OP_LOCK, 1'b0, `LK_M}) begin
              d.settle = SETTLE_CYC;
            end
          end else begin
            d.fsm = led_link_pkg::H_IDLE; // one half period gap kept
          end
        end
      end
      default: d.fsm = led_link_pkg::H_IDLE;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= RST_IMG;
    end else begin
      q <= d;
    end
  end

  // link pins and read data straight from flops
  assign link.link_clk = q.lclk;
  assign link.sin = q.sinb;
  assign link.latch = q.latch;
  assign rdata = q.rdata;

endmodule

/* tb/led_link_sva.sv */
// Purpose: link framing and lock checks beside the led link
// Assumes: one clock domain, core_clk with resetn
// Notes: locked groups must never move until reset
`timescale 1ns/1ps
module led_link_sva (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic sin,
  input wire logic latch,
  input wire logic [5:0] ctrl1_word,
  input wire logic [6:0] ctrl2_word,
  input wire logic [95:0] current_codes,
  input wire logic [35:0] pwm_select,
  input wire logic [1:0] pwm_steps,
  input wire logic [3:0] frame_rate,
  input wire logic [59:0] duty_values,
  input wire logic [11:0] output_enable_mask,
  input wire logic [23:0] short_threshold,
  input wire logic [11:0] led_drive,
  input wire logic [4:0] lock_flags
);
  // ****************
  // assertions
  // ****************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // link clock parked low between frames
  chk_clock_in_frame: assert property (!latch |-> !link_clk)
    else $error("link clock toggles outside a frame");
  // data settled when the far end samples it
  chk_sin_at_rise: assert property ($rose(link_clk) |-> $stable(sin))
    else $error("serial data moved at link clock rise");
  chk_locks_sticky: assert property ((lock_flags & $past(lock_flags))
    == $past(lock_flags))
    else $error("lock flag dropped without reset");
  chk_ctrl_held: assert property (lock_flags[0] && $past(lock_flags[0])
    |-> $stable({ctrl1_word, ctrl2_word}))
    else $error("locked control words changed");
  chk_current_held: assert property (lock_flags[1] && $past(lock_flags[1])
    |-> $stable(current_codes))
    else $error("locked current codes changed");
  chk_pwm_held: assert property (lock_flags[2] && $past(lock_flags[2])
    |-> $stable({pwm_select, pwm_steps, frame_rate}))
    else $error("locked pwm setup changed");
  chk_duty_held: assert property (lock_flags[3] && $past(lock_flags[3])
    |-> $stable(duty_values))
    else $error("locked duty values changed");
  chk_mask_held: assert property (lock_flags[4] && $past(lock_flags[4])
    |-> $stable({output_enable_mask, short_threshold}))
    else $error("locked masks changed");
  // outputs light only after the mask lock, and only where enabled
  chk_led_gated: assert property (|led_drive
    |-> lock_flags[4] && !(led_drive & ~output_enable_mask))
    else $error("led driven without lock or enable");
  cover property (lock_flags == 5'h1F);
  cover property (|led_drive);
  cover property ($fell(latch));
endmodule

/* tb/tb.sv */
// Purpose: drives both link ends through the host register port
// Assumes: settle wait shortened to 50 core cycles
// Notes: fault inputs come from one bench vector
`timescale 1ns/1ps
`include "led_link_defines.svh"
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [11:0] fin = 12'h000; // fault stimulus toward the device
  logic [5:0] ctrl1_word;
  logic [6:0] ctrl2_word;
  logic [95:0] current_codes;
  logic [35:0] pwm_select;
  logic [1:0] pwm_steps;
  logic [3:0] frame_rate;
  logic [59:0] duty_values;
  logic [11:0] output_enable_mask;
  logic [23:0] short_threshold;
  logic [11:0] led_drive;
  logic [4:0] lock_flags;
  logic [95:0] got; // last read payload
  logic [95:0] pat [11]; // written value per register
  logic [6:0] wid [11] = '{6, 7, 96, 36, 6, 60, 12, 12, 12, 12, 24};
  int fails = 0;
  int check_count = 0;
  int i;
  int lg = 0; // next lock group to close
  led_link_if lk();
  led_cfg_host #(.SETTLE_CYC(50)) led_cfg_host_i (.core_clk, .resetn, .link(lk), .addr,
    .wdata, .wr, .rd, .rdata);
  led_cfg_device led_cfg_device_i (.core_clk, .resetn, .link(lk), .temp_warn(fin[0]),
    .temp_shutdown(fin[1]), .supply_fault(fin[2]), .clock_fault(fin[3]),
    .ir_result(fin[5:4]), .supply_short_result(fin), .ground_short_result(fin),
    .open_result(fin), .adjacent_short_result(fin), .output_state_result(fin), .ctrl1_word,
    .ctrl2_word, .current_codes, .pwm_select, .pwm_steps, .frame_rate, .duty_values,
    .output_enable_mask, .supply_short_mask(), .ground_short_mask(), .open_detect_mask(),
    .short_threshold, .led_drive, .lock_flags);
  led_link_sva led_link_sva_i (.core_clk, .resetn, .link_clk(lk.link_clk), .sin(lk.sin),
    .latch(lk.latch), .ctrl1_word, .ctrl2_word, .current_codes, .pwm_select, .pwm_steps,
    .frame_rate, .duty_values, .output_enable_mask, .short_threshold, .led_drive,
    .lock_flags);
  // ****************
  // tasks
  // ****************
  initial forever #4 core_clk = ~core_clk;
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d, checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one strobe cycle; read data taken in the cycle after
  task automatic bus(input logic [4:0] a, input logic [31:0] d, input logic w,
      output logic [31:0] q);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  // one frame; busy and settling both polled, bounded
  task automatic xfer(input logic [7:0] c, input logic [6:0] n, input logic [95:0] w);
    logic [31:0] q;
    int k;
    bus(`HA_WD0, w[31:0], 1'b1, q);
    bus(`HA_WD1, w[63:32], 1'b1, q);
    bus(`HA_WD2, w[95:64], 1'b1, q);
    bus(`HA_CMD, {17'h0, n, c}, 1'b1, q);
    q = 32'h1;
    for (k = 0; k < 4000 && q[1:0] != 2'h0; k++) begin
      bus(`HA_STAT, 32'h0, 1'b0, q);
    end
    if (q[1:0] != 2'h0) begin
      fails++;
      print_verdict();
    end
    bus(`HA_RD0, 32'h0, 1'b0, got[31:0]);
    bus(`HA_RD1, 32'h0, 1'b0, got[63:32]);
    bus(`HA_RD2, 32'h0, 1'b0, got[95:64]);
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge core_clk);
    xfer(8'h50, 7'd8, 96'h0);
    chk(got, 96'hFF);
    xfer(8'h40, 7'd0, 96'h0);
    xfer(8'h41, 7'd0, 96'h0);
    xfer(8'h50, 7'd8, 96'h0);
    // clock fault flag is not cleared by the status clear, only by its check
    chk(got, 96'h40);
    xfer(8'h51, 7'd5, 96'h0);
    chk(got, 96'h0);
    // each group is written, read back and locked before the next one
    for (i = 0; i < 11; i++) begin
      pat[i] = ({8{12'h5A3}} + 96'(i)) & ~({96{1'b1}} << wid[i]);
      xfer({4'h1, 4'(i)}, wid[i], pat[i]);
      xfer({4'h2, 4'(i)}, wid[i], 96'h0);
      chk(got, pat[i]);
      if (i == 1 || i == 2 || i == 4 || i == 5 || i == 10) begin
        xfer({4'h3, 4'(lg)}, 7'd0, 96'h0);
        lg++;
      end
      // clock check after the control lock, before any current code
      if (i == 1) begin
        xfer(8'h42, 7'd0, 96'h0);
        xfer(8'h50, 7'd8, 96'h0);
        chk(got, 96'h0);
      end
    end
    xfer(8'h50, 7'd8, 96'h0);
    chk(got, 96'h0);
    xfer(8'h51, 7'd5, 96'h0);
    chk(got, 96'h1F);
    chk(current_codes, pat[2]);
    chk(duty_values, pat[5]);
    chk(led_drive, pat[6]);
    chk({pwm_steps, frame_rate}, pat[4]);
    chk(short_threshold, pat[10]);
    // locked groups keep their contents against new writes
    for (i = 0; i < 11; i++) begin
      xfer({4'h1, 4'(i)}, wid[i], ~pat[i] & ~({96{1'b1}} << wid[i]));
      xfer({4'h2, 4'(i)}, wid[i], 96'h0);
      chk(got, pat[i]);
    end
    @(posedge core_clk);
    fin <= 12'h5A4;
    for (i = 2; i < 8; i++) begin
      xfer({4'h5, 4'(i)}, (i == 2) ? 7'd2 : 7'd12, 96'h0);
      chk(got, (i == 2) ? 96'h2 : 96'h5A4);
    end
    print_verdict();
  end
endmodule
